// file: rtl/async_gen_regs.vh
// Register map, field layout and timing constants for the asynchronous generator sequencer
//
// Functional notes
// - Asynchronous generator only in mains-parallel plants.
// - Generator type setting selects sync or async.
// - Start engine only with mains and parallel allowed.
// - Started and speed conditions from rotation speed.
// - Check bar voltage, close breaker unsynchronized.
// - Min/max thresholds are percent of nominal speed.
// - Bands absent, hysteresis, low, tolerance, high.
// - Hysteresis above minimum and below maximum.
// - In hysteresis zones keep previous status.
// - Operating speed equals generator within tolerance.
// - Magnetization output while resistances wanted.
// - Magnetize one second, then command breaker close.
// - Closed feedback drops magnetization, sequence done.
// - No close in three seconds: drop, cool, retry.
// - Each close attempt limited to two seconds.
// - Cooldown blocks new breaker closing.
// - Capacitors inserted after delay from breaker closure.
// - Capacitors dropped immediately when breaker opens.
// - Rated current from rated power and voltage.
`ifndef ASYNC_GEN_REGS_VH
`define ASYNC_GEN_REGS_VH

// Byte addresses
`define REG_CTRL 12'h000
`define REG_SPEED_NOM 12'h004
`define REG_THR_STOP 12'h008
`define REG_THR_START 12'h00C
`define REG_THR_MIN 12'h010
`define REG_THR_MAX 12'h014
`define REG_HYST 12'h018
`define REG_COOL 12'h01C
`define REG_CAP_DLY 12'h020
`define REG_RATED_PWR 12'h024
`define REG_RATED_VOLT 12'h028
`define REG_SPEED 12'h02C
`define REG_STATUS 12'h030
`define REG_CURRENT 12'h034

// Control register fields
`define CTRL_ASYNC 0
`define CTRL_THREE_PHASE 1
`define CTRL_PARALLEL_PLANT 2
`define CTRL_UNSYNC_BRK 3
`define CTRL_PAR_ALLOWED 4
`define CTRL_CLOSE_REQ 5

// Reset values: thresholds in tenths of a percent, speed in rpm
`define RST_SPEED_NOM 16'h05DC
`define RST_THR_STOP 16'h0046
`define RST_THR_START 16'h00C8
`define RST_THR_MIN 16'h0384
`define RST_THR_MAX 16'h044C
`define RST_HYST 16'h0019
`define RST_COOL 16'h001E
`define RST_CAP_DLY 16'h0005
`define RST_RATED_PWR 16'h0064
`define RST_RATED_VOLT 16'h0190

// Speed bands
`define BAND_ABSENT 3'h0
`define BAND_LOW 3'h1
`define BAND_TOL 3'h2
`define BAND_HIGH 3'h3

// Timing: clock 10 MHz, tick 100 ms
`define CLK_HZ 10000000
`define TICK_MS 100
`define TICK_CYC ((`CLK_HZ / 1000) * `TICK_MS)
`define TICKS_PER_S (1000 / `TICK_MS)
`define MAGNETIZE_S 1
`define ATTEMPT_S 2
`define PERMILLE 1000
`define KW_SCALE 1000
`define SQRT3_X1000 1732

`endif

// file: rtl/async_generator_closing_sequencer.v
// Asynchronous generator speed bands, breaker closing sequence and capacitor control
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "async_gen_regs.vh"

module async_generator_closing_sequencer #(
    parameter TICK_CYCLES = `TICK_CYC
)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire mains_present,
    input wire bars_live,
    input wire generator_breaker_closed,
    output reg engine_start_r,
    output reg magnetization_output_function_r,
    output reg generator_breaker_close_r,
    output reg capacitor_output_function_r,
    output reg operating_speed_r
);

////////////////////////////////////////////////////////////////////////////////
// Configuration registers

reg [6:0] ctrl_r;
reg [15:0] speed_nom_r;
reg [15:0] thr_stop_r;
reg [15:0] thr_start_r;
reg [15:0] thr_min_r;
reg [15:0] thr_max_r;
reg [15:0] hyst_r;
reg [15:0] cool_r;
reg [15:0] cap_dly_r;
reg [15:0] rated_pwr_r;
reg [15:0] rated_volt_r;
reg [15:0] speed_r;

wire wr_en = psel && penable && pwrite;
wire rd_en = psel && !penable && !pwrite;
wire addr_ok = (paddr <= `REG_CURRENT) && (paddr[1:0] == 2'b00);

assign pready = 1'b1;
assign pslverr = psel && penable && !addr_ok;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ctrl_r <= 7'h00;
        speed_nom_r <= `RST_SPEED_NOM;
        thr_stop_r <= `RST_THR_STOP;
        thr_start_r <= `RST_THR_START;
        thr_min_r <= `RST_THR_MIN;
        thr_max_r <= `RST_THR_MAX;
        hyst_r <= `RST_HYST;
        cool_r <= `RST_COOL;
        cap_dly_r <= `RST_CAP_DLY;
        rated_pwr_r <= `RST_RATED_PWR;
        rated_volt_r <= `RST_RATED_VOLT;
        speed_r <= 16'h0000;
    end
    else if (wr_en)
    begin
        if (paddr == `REG_CTRL)
            ctrl_r <= pwdata[6:0];
        else if (paddr == `REG_SPEED_NOM)
            speed_nom_r <= pwdata[15:0];
        else if (paddr == `REG_THR_STOP)
            thr_stop_r <= pwdata[15:0];
        else if (paddr == `REG_THR_START)
            thr_start_r <= pwdata[15:0];
        else if (paddr == `REG_THR_MIN)
            thr_min_r <= pwdata[15:0];
        else if (paddr == `REG_THR_MAX)
            thr_max_r <= pwdata[15:0];
        else if (paddr == `REG_HYST)
            hyst_r <= pwdata[15:0];
        else if (paddr == `REG_COOL)
            cool_r <= pwdata[15:0];
        else if (paddr == `REG_CAP_DLY)
            cap_dly_r <= pwdata[15:0];
        else if (paddr == `REG_RATED_PWR)
            rated_pwr_r <= pwdata[15:0];
        else if (paddr == `REG_RATED_VOLT)
            rated_volt_r <= pwdata[15:0];
        else if (paddr == `REG_SPEED)
            speed_r <= pwdata[15:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Mode qualification

wire async_mode = ctrl_r[`CTRL_ASYNC];
wire async_ok = async_mode && ctrl_r[`CTRL_PARALLEL_PLANT] && ctrl_r[`CTRL_UNSYNC_BRK];

////////////////////////////////////////////////////////////////////////////////
// Evaluation tick

reg [23:0] tick_cnt_r;
reg tick_r;
localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        tick_cnt_r <= 24'h000000;
        tick_r <= 1'b0;
    end
    else if (tick_cnt_r == TICK_LAST[23:0])
    begin
        tick_cnt_r <= 24'h000000;
        tick_r <= 1'b1;
    end
    else
    begin
        tick_cnt_r <= tick_cnt_r + 24'h000001;
        tick_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Speed thresholds in rpm, all relative to nominal speed

function [15:0] pct_of;
    input [15:0] nom;
    input [15:0] permille;
    reg [31:0] prod;
    reg [31:0] quot;
    begin
        prod = nom * permille;
        quot = prod / `PERMILLE;
        pct_of = quot[15:0];
    end
endfunction

wire [15:0] rpm_stop = pct_of(speed_nom_r, thr_stop_r);
wire [15:0] rpm_start = pct_of(speed_nom_r, thr_start_r);
wire [15:0] rpm_min = pct_of(speed_nom_r, thr_min_r);
wire [15:0] rpm_max = pct_of(speed_nom_r, thr_max_r);
wire [15:0] rpm_hyst = pct_of(speed_nom_r, hyst_r);
wire [15:0] rpm_min_hi = rpm_min + rpm_hyst;
wire [15:0] rpm_max_lo = rpm_max - rpm_hyst;

////////////////////////////////////////////////////////////////////////////////
// Band classification with hysteresis

reg [2:0] band_r;
reg [2:0] band_nxt;

always @*
begin
    band_nxt = band_r;
    if (speed_r < rpm_stop)
        band_nxt = `BAND_ABSENT;
    else if (speed_r < rpm_start)
        band_nxt = band_r;
    else if (speed_r < rpm_min)
        band_nxt = `BAND_LOW;
    else if (speed_r < rpm_min_hi)
        band_nxt = (band_r == `BAND_TOL) ? `BAND_TOL : `BAND_LOW;
    else if (speed_r <= rpm_max_lo)
        band_nxt = `BAND_TOL;
    else if (speed_r <= rpm_max)
        band_nxt = (band_r == `BAND_HIGH) ? `BAND_HIGH : `BAND_TOL;
    else
        band_nxt = `BAND_HIGH;
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        band_r <= `BAND_ABSENT;
    else if (tick_r)
        band_r <= band_nxt;
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        operating_speed_r <= 1'b0;
        engine_start_r <= 1'b0;
    end
    else
    begin
        operating_speed_r <= async_ok && (band_r == `BAND_TOL);
        engine_start_r <= async_ok && mains_present && ctrl_r[`CTRL_PAR_ALLOWED];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Breaker closing sequencer

localparam ST_IDLE = 3'd0;
localparam ST_MAGN = 3'd1;
localparam ST_CLOSE = 3'd2;
localparam ST_DONE = 3'd3;
localparam ST_COOL = 3'd4;

localparam [31:0] MAGN_TICKS_W = `MAGNETIZE_S * `TICKS_PER_S;
localparam [31:0] ATTEMPT_TICKS_W = `ATTEMPT_S * `TICKS_PER_S;
localparam [15:0] MAGN_TICKS = MAGN_TICKS_W[15:0];
localparam [15:0] ATTEMPT_TICKS = ATTEMPT_TICKS_W[15:0];

reg [2:0] state_r;
reg [15:0] timer_r;
wire [31:0] cool_ticks_w = cool_r * `TICKS_PER_S;
wire [15:0] cool_ticks = cool_ticks_w[15:0];
wire close_ok = async_ok && ctrl_r[`CTRL_CLOSE_REQ] && operating_speed_r && bars_live;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_r <= ST_IDLE;
        timer_r <= 16'h0000;
        magnetization_output_function_r <= 1'b0;
        generator_breaker_close_r <= 1'b0;
    end
    else
    begin
        case (state_r)
            ST_IDLE:
            begin
                if (close_ok && !generator_breaker_closed)
                begin
                    state_r <= ST_MAGN;
                    timer_r <= 16'h0000;
                    magnetization_output_function_r <= 1'b1;
                end
            end
            ST_MAGN:
            begin
                if (generator_breaker_closed)
                begin
                    state_r <= ST_DONE;
                    magnetization_output_function_r <= 1'b0;
                end
                else if (tick_r && timer_r == MAGN_TICKS - 16'h0001)
                begin
                    state_r <= ST_CLOSE;
                    timer_r <= 16'h0000;
                    generator_breaker_close_r <= 1'b1;
                end
                else if (tick_r)
                    timer_r <= timer_r + 16'h0001;
            end
            ST_CLOSE:
            begin
                if (generator_breaker_closed)
                begin
                    state_r <= ST_DONE;
                    magnetization_output_function_r <= 1'b0;
                end
                else if (tick_r && timer_r == ATTEMPT_TICKS - 16'h0001)
                begin
                    state_r <= ST_COOL;
                    timer_r <= 16'h0000;
                    generator_breaker_close_r <= 1'b0;
                    magnetization_output_function_r <= 1'b0;
                end
                else if (tick_r)
                    timer_r <= timer_r + 16'h0001;
            end
            ST_DONE:
            begin
                if (!generator_breaker_closed)
                begin
                    state_r <= ST_IDLE;
                    generator_breaker_close_r <= 1'b0;
                end
                else if (!async_ok)
                    generator_breaker_close_r <= 1'b0;
            end
            ST_COOL:
            begin
                if (timer_r >= cool_ticks)
                    state_r <= ST_IDLE;
                else if (tick_r)
                    timer_r <= timer_r + 16'h0001;
            end
            default:
                state_r <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Power-factor capacitors

reg [15:0] cap_timer_r;
wire [31:0] cap_ticks_w = cap_dly_r * `TICKS_PER_S;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cap_timer_r <= 16'h0000;
        capacitor_output_function_r <= 1'b0;
    end
    else if (!generator_breaker_closed || !async_ok)
    begin
        cap_timer_r <= 16'h0000;
        capacitor_output_function_r <= 1'b0;
    end
    else if (cap_timer_r >= cap_ticks_w[15:0])
        capacitor_output_function_r <= 1'b1;
    else if (tick_r)
        cap_timer_r <= cap_timer_r + 16'h0001;
end

////////////////////////////////////////////////////////////////////////////////
// Rated current in amperes

reg [31:0] current_r;
wire [31:0] pwr_w = rated_pwr_r * `KW_SCALE;
wire [31:0] volt_w = {16'h0000, rated_volt_r};
wire [31:0] i1_w = (volt_w == 32'h0) ? 32'h0 : pwr_w / volt_w;
wire [47:0] num3_w = pwr_w * `SQRT3_X1000;
wire [47:0] den3_w = volt_w * 3 * `PERMILLE;
wire [47:0] i3_w = (volt_w == 32'h0) ? 48'h0 : num3_w / den3_w;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        current_r <= 32'h00000000;
    else
        current_r <= ctrl_r[`CTRL_THREE_PHASE] ? i3_w[31:0] : i1_w;
end

////////////////////////////////////////////////////////////////////////////////
// Read data

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        prdata <= 32'h00000000;
    else if (rd_en)
    begin
        if (paddr == `REG_CTRL)
            prdata <= {25'h0, ctrl_r};
        else if (paddr == `REG_SPEED_NOM)
            prdata <= {16'h0, speed_nom_r};
        else if (paddr == `REG_THR_STOP)
            prdata <= {16'h0, thr_stop_r};
        else if (paddr == `REG_THR_START)
            prdata <= {16'h0, thr_start_r};
        else if (paddr == `REG_THR_MIN)
            prdata <= {16'h0, thr_min_r};
        else if (paddr == `REG_THR_MAX)
            prdata <= {16'h0, thr_max_r};
        else if (paddr == `REG_HYST)
            prdata <= {16'h0, hyst_r};
        else if (paddr == `REG_COOL)
            prdata <= {16'h0, cool_r};
        else if (paddr == `REG_CAP_DLY)
            prdata <= {16'h0, cap_dly_r};
        else if (paddr == `REG_RATED_PWR)
            prdata <= {16'h0, rated_pwr_r};
        else if (paddr == `REG_RATED_VOLT)
            prdata <= {16'h0, rated_volt_r};
        else if (paddr == `REG_SPEED)
            prdata <= {16'h0, speed_r};
        else if (paddr == `REG_STATUS)
            prdata <= {21'h0, state_r, band_r, capacitor_output_function_r,
                       generator_breaker_close_r, magnetization_output_function_r,
                       operating_speed_r, engine_start_r};
        else if (paddr == `REG_CURRENT)
            prdata <= current_r;
        else
            prdata <= 32'h00000000;
    end
end

endmodule

// file: bench/async_gen_monitor.sv
// Port-level checks of the asynchronous generator closing sequencer
`timescale 1ns/100ps
module async_gen_monitor #(
    parameter TICK_CYCLES = 10
)
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [11:0] paddr,
    input wire pready,
    input wire pslverr,
    input wire mains_present,
    input wire bars_live,
    input wire generator_breaker_closed,
    input wire engine_start_r,
    input wire magnetization_output_function_r,
    input wire generator_breaker_close_r,
    input wire capacitor_output_function_r,
    input wire operating_speed_r
);
    reg [31:0] magn_cnt;
    // Cycles the resistances have been connected in a row
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            magn_cnt <= 32'h0;
        else if (magnetization_output_function_r)
            magn_cnt <= magn_cnt + 32'h1;
        else
            magn_cnt <= 32'h0;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    a_apb_ready: assert property (psel |-> pready) else $error("pready low");
    a_unmapped_err: assert property (psel && penable && paddr > 12'h034 |-> pslverr)
        else $error("no slave error");
    a_start_gate: assert property (engine_start_r |-> $past(mains_present))
        else $error("start without mains");
    a_magn_entry: assert property ($rose(magnetization_output_function_r) |->
        $past(operating_speed_r) && $past(bars_live) && !$past(generator_breaker_closed))
        else $error("magnetization without conditions");
    a_magn_time: assert property ($rose(generator_breaker_close_r) |->
        magnetization_output_function_r && magn_cnt >= 9 * TICK_CYCLES
        && magn_cnt <= 10 * TICK_CYCLES + 2) else $error("close command timing");
    a_magn_limit: assert property (magn_cnt <= 30 * TICK_CYCLES + 2)
        else $error("resistances on too long");
    a_fb_drops: assert property (generator_breaker_closed && generator_breaker_close_r
        |=> !magnetization_output_function_r) else $error("magnetization kept");
    a_close_alone: assert property (generator_breaker_close_r
        && !magnetization_output_function_r |-> $past(generator_breaker_closed))
        else $error("close without magnetization");
    a_cool_block: assert property ($fell(magnetization_output_function_r)
        && !generator_breaker_closed |-> !magnetization_output_function_r [*8])
        else $error("retry during cooldown");
    a_cap_drop: assert property (!generator_breaker_closed
        |=> !capacitor_output_function_r) else $error("capacitor kept");
    a_cap_after: assert property ($rose(capacitor_output_function_r)
        |-> $past(generator_breaker_closed, 2)) else $error("capacitor early");
endmodule

// file: bench/breaker_model.sv
// Behavioural generator breaker with adjustable closing latency
`timescale 1ns/100ps
module breaker_model (
    input wire pclk,
    input wire presetn,
    input wire close_cmd,
    input wire can_close,
    input wire trip,
    input wire [3:0] lat,
    output reg closed
);
    reg [3:0] cnt_r;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            closed <= 1'b0;
            cnt_r <= 4'h0;
        end
        else if (trip)
            closed <= 1'b0;
        else if (close_cmd && can_close && !closed)
        begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == lat)
                closed <= 1'b1;
        end
        else
            cnt_r <= 4'h0;
    end
endmodule

// file: bench/async_generator_closing_sequencer_tb.sv
// Self-checking bench of the asynchronous generator closing sequencer
`timescale 1ns/100ps
`include "async_gen_regs.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module async_generator_closing_sequencer_tb;
    localparam int T = 10;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, m, e;
    logic pready, pslverr, mains_present = 1'b1, bars_live = 1'b1, closed;
    logic can_close = 1'b0, trip = 1'b0;
    logic [3:0] lat = 4'h3;
    logic eng, opsp, magn, clo, cap;
    logic [31:0] exp_q[$], msk_q[$];
    logic [31:0] seed = 32'h2815;
    logic [15:0] s;
    logic [15:0] rv[11] = '{16'h0000, `RST_SPEED_NOM, `RST_THR_STOP, `RST_THR_START,
        `RST_THR_MIN, `RST_THR_MAX, `RST_HYST, `RST_COOL, `RST_CAP_DLY, `RST_RATED_PWR,
        `RST_RATED_VOLT};
    logic [15:0] sp[11] = '{16'h0, 16'hC8, 16'h320, 16'h55A, 16'h5DC, 16'h55A, 16'h65E,
        16'h6A4, 16'h65E, 16'h32, 16'h5DC};
    logic [2:0] bd[11] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h0, 3'h2};
    logic [7:0] bad[3] = '{8'h1C, 8'h19, 8'h15};
    int n_fail = 0, total_checks = 0;
    wire [2:0] outs = {cap, clo, magn};
    always #50 pclk = ~pclk;
    async_generator_closing_sequencer #(.TICK_CYCLES(T)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mains_present(mains_present),
        .bars_live(bars_live), .generator_breaker_closed(closed), .engine_start_r(eng),
        .magnetization_output_function_r(magn), .generator_breaker_close_r(clo),
        .capacitor_output_function_r(cap), .operating_speed_r(opsp));
    breaker_model u_brk (.pclk(pclk), .presetn(presetn), .close_cmd(clo), .can_close(can_close),
        .trip(trip), .lat(lat), .closed(closed));
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] st(input logic mg, cl, cp, input logic [2:0] q);
        return {21'h0, q, 3'h0, cp, cl, mg, 2'h0};
    endfunction
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] mk, input logic [31:0] ev);
        msk_q.push_back(mk);
        exp_q.push_back(ev & mk);
        apb(1'b0, a, 32'h0);
    endtask
    // Waits a bounded span for one sequencer output to take a level
    task automatic wt(input int k, input logic v, input int n);
        int i;
        for (i = 0; i < n && outs[k] !== v; i++)
            @(posedge pclk);
        `CHK("output", v, outs[k])
    endtask
    task automatic results;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite && msk_q.size() > 0)
        begin
            m = msk_q.pop_front();
            e = exp_q.pop_front();
            `CHK("prdata", e, prdata & m)
        end
    initial
    begin
        #2000000;
        n_fail++;
        results;
    end
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 11; i++)
            rd(12'(i * 4), 32'hFFFFFFFF, {16'h0, rv[i]});
        rd(12'h040, 32'hFFFFFFFF, 32'h0);
        rd(`REG_CURRENT, 32'hFFFFFFFF, 32'hFA);
        apb(1'b1, `REG_STATUS, rnd());
        rd(`REG_STATUS, 32'h71F, 32'h0);
        apb(1'b1, `REG_CTRL, 32'h2);
        rd(`REG_CURRENT, 32'hFFFFFFFF, 32'h90);
        apb(1'b1, `REG_COOL, 32'h1);
        apb(1'b1, `REG_CAP_DLY, 32'h1);
        apb(1'b1, `REG_CTRL, 32'h1D);
        for (int i = 0; i < 11; i++)
        begin
            s = (sp[i] == 16'h5DC) ? 16'h578 + 16'(rnd() % 200) : sp[i];
            apb(1'b1, `REG_SPEED, {16'h0, s});
            repeat (2 * T) @(posedge pclk);
            rd(`REG_STATUS, 32'hE3, {24'h0, bd[i], 3'h0, bd[i] == 3'h2, 1'b1});
        end
        // Sync mode, no unsynchronised breaker, no parallel plant
        for (int j = 0; j < 3; j++)
        begin
            apb(1'b1, `REG_CTRL, {24'h0, bad[j]});
            repeat (2 * T) @(posedge pclk);
            rd(`REG_STATUS, 32'h3, 32'h0);
        end
        apb(1'b1, `REG_CTRL, 32'h1D);
        mains_present <= 1'b0;
        repeat (2 * T) @(posedge pclk);
        rd(`REG_STATUS, 32'h3, 32'h2);
        mains_present <= 1'b1;
        bars_live <= 1'b0;
        apb(1'b1, `REG_CTRL, 32'h3D);
        repeat (2 * T) @(posedge pclk);
        rd(`REG_STATUS, 32'h71C, st(0, 0, 0, 0));
        bars_live <= 1'b1;
        wt(0, 1'b1, 4 * T);
        rd(`REG_STATUS, 32'h71C, st(1, 0, 0, 1));
        repeat (7 * T) @(posedge pclk);
        rd(`REG_STATUS, 32'h71C, st(1, 0, 0, 1));
        wt(1, 1'b1, 3 * T);
        rd(`REG_STATUS, 32'h71C, st(1, 1, 0, 2));
        repeat (17 * T) @(posedge pclk);
        rd(`REG_STATUS, 32'h71C, st(1, 1, 0, 2));
        wt(0, 1'b0, 4 * T);
        rd(`REG_STATUS, 32'h71C, st(0, 0, 0, 4));
        repeat (6 * T) @(posedge pclk);
        rd(`REG_STATUS, 32'h71C, st(0, 0, 0, 4));
        lat <= 4'(rnd() % 8);
        can_close <= 1'b1;
        wt(0, 1'b1, 6 * T);
        wt(1, 1'b1, 12 * T);
        wt(0, 1'b0, T);
        rd(`REG_STATUS, 32'h71C, st(0, 1, 0, 3));
        wt(2, 1'b1, 12 * T);
        trip <= 1'b1;
        wt(2, 1'b0, 4);
        results;
    end
endmodule
bind async_generator_closing_sequencer async_gen_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .mains_present(mains_present), .bars_live(bars_live),
    .generator_breaker_closed(generator_breaker_closed), .engine_start_r(engine_start_r),
    .magnetization_output_function_r(magnetization_output_function_r),
    .generator_breaker_close_r(generator_breaker_close_r),
    .capacitor_output_function_r(capacitor_output_function_r),
    .operating_speed_r(operating_speed_r));
